// >>> scl_current_fsm.sv
`timescale 1ns/1ps

// Function
// - Run only when attached on default VBUS
// - Enter default sub-state on attach
// - Later sub-states follow advertised level; mid to high also needs high_current_enable
// - Leave sub-states on VBUS loss or contract
// - Low-power sink may stay in default
// - Default sub-state limits draw to default
// - Default sub-state monitors voltage if wanting more
// - Act only after range stable for debounce
// - Debounced mid or high raises sub-state
// - Mid sub-state limits draw to 1.5 A
// - Mid and high sub-states keep monitoring
// - Default range drops to default within deadline
// - High sub-state limits draw to 3.0 A
// - Mid range from high drops within deadline
// - Passthrough sink adds tighter current ceiling
module scl_current_fsm #(
  parameter int unsigned DEBOUNCE_CYC = scl_pkg::ADVERT_DEBOUNCE_CYC,
  parameter int unsigned REDUCE_CYC = scl_pkg::REDUCE_DEADLINE_CYC,
  parameter logic [scl_pkg::MA_W-1:0] PASSTHROUGH_MA = scl_pkg::PASSTHROUGH_LIMIT_MA
) (
  input wire logic mclk,
  input wire logic rst,
  input wire scl_pkg::scl_link_t link,
  input wire logic [1:0] sensed_cc_voltage,
  input wire logic high_current_enable,
  output scl_pkg::scl_grant_t grant,
  output logic advert_change_pulse,
  output logic raise_withheld
);

  localparam int unsigned DB_W = $clog2(DEBOUNCE_CYC + 1);
  localparam int unsigned RD_W = $clog2(REDUCE_CYC + 1);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYC);
  localparam logic [RD_W-1:0] RD_LAST = RD_W'(REDUCE_CYC);

  // Comparator outputs are asynchronous to mclk
  logic [1:0] cc_meta_r;
  logic [1:0] cc_sync_r;

  scl_pkg::scl_state_t state_r;
  scl_pkg::scl_state_t state_nxt;
  logic [1:0] cand_r;
  logic [DB_W-1:0] db_cnt_r;
  logic [DB_W-1:0] db_cnt_nxt;
  logic [RD_W-1:0] rd_cnt_r;
  logic [RD_W-1:0] rd_cnt_nxt;
  scl_pkg::scl_grant_t grant_r;
  scl_pkg::scl_grant_t grant_nxt;
  logic advert_change_r;
  logic raise_withheld_r;

  wire logic attached;
  wire logic active;
  wire logic in_idle;
  wire logic in_default;
  wire logic in_mid;
  wire logic in_high;
  wire logic monitor_en;
  wire logic range_moved;
  wire logic stable;
  wire logic seen_default;
  wire logic seen_mid;
  wire logic seen_high;
  wire logic go_default;
  wire logic go_mid;
  wire logic go_high;
  wire logic drop;
  wire logic raise_blocked;
  wire logic [scl_pkg::MA_W-1:0] state_ma;
  wire logic [scl_pkg::MA_W-1:0] capped_ma;
  wire logic nxt_high;
  wire logic nxt_mid;
  wire logic over_cap;
  wire logic substate_moves;
  wire logic code_wants_more;

  // First stage may go metastable; only the second stage is read
  always_ff @(posedge mclk) begin
    if (rst) begin
      cc_meta_r <= 2'h0;
    end else begin
      cc_meta_r <= sensed_cc_voltage;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cc_sync_r <= 2'h0;
    end else begin
      cc_sync_r <= cc_meta_r;
    end
  end

  assign attached = link.sink_attached_state | link.passthrough_sink_attached_state;
  // exit on VBUS loss or contract
  assign active = attached & link.vbus_default & ~link.pd_contract;

  assign in_idle = (state_r == scl_pkg::SCL_IDLE);
  assign in_default = (state_r == scl_pkg::SCL_DEFAULT);
  assign in_mid = (state_r == scl_pkg::SCL_MID);
  assign in_high = (state_r == scl_pkg::SCL_HIGH);

  // default watches only when more is wanted
  assign monitor_en = active & ((in_default & high_current_enable) | in_mid | in_high);

  // any new reading restarts the timer
  assign range_moved = (cc_sync_r != cand_r);
  // stable for the full debounce time
  assign stable = monitor_en & ~range_moved & (db_cnt_r == DB_LAST);

  assign seen_default = stable & (cand_r == scl_pkg::SCL_RANGE_DEFAULT);
  assign seen_mid = stable & (cand_r == scl_pkg::SCL_RANGE_MID);
  assign seen_high = stable & (cand_r == scl_pkg::SCL_RANGE_HIGH);

  // moves follow the debounced advertisement; raises also need high_current_enable
  // no raise unless high current is wanted
  assign go_mid = (in_default & seen_mid & high_current_enable) | (in_high & seen_mid);
  assign go_high = (in_default | in_mid) & seen_high & high_current_enable;
  // back to default from mid or high
  assign go_default = (in_mid | in_high) & seen_default;
  // high to mid is also a reduction
  assign drop = go_default | (in_high & seen_mid);

  // report a higher offer that is left unused
  assign code_wants_more = (cc_sync_r == scl_pkg::SCL_RANGE_MID) | (cc_sync_r == scl_pkg::SCL_RANGE_HIGH);
  assign raise_blocked = active & in_default & ~high_current_enable & ~range_moved & code_wants_more;

  // Counter stops at the last count so a settled reading stays accepted
  always_comb begin
    db_cnt_nxt = db_cnt_r;
    if (!monitor_en || range_moved) begin
      db_cnt_nxt = '0;
    end else if (db_cnt_r != DB_LAST) begin
      db_cnt_nxt = db_cnt_r + DB_W'(1);
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      scl_pkg::SCL_IDLE: begin
        if (active) begin
          state_nxt = scl_pkg::SCL_DEFAULT;
        end
      end
      scl_pkg::SCL_DEFAULT: begin
        if (!active) begin
          state_nxt = scl_pkg::SCL_IDLE;
        end else if (go_high) begin
          state_nxt = scl_pkg::SCL_HIGH;
        end else if (go_mid) begin
          state_nxt = scl_pkg::SCL_MID;
        end
      end
      scl_pkg::SCL_MID: begin
        if (!active) begin
          state_nxt = scl_pkg::SCL_IDLE;
        end else if (go_high) begin
          state_nxt = scl_pkg::SCL_HIGH;
        end else if (go_default) begin
          state_nxt = scl_pkg::SCL_DEFAULT;
        end
      end
      scl_pkg::SCL_HIGH: begin
        if (!active) begin
          state_nxt = scl_pkg::SCL_IDLE;
        end else if (go_default) begin
          state_nxt = scl_pkg::SCL_DEFAULT;
        end else if (go_mid) begin
          state_nxt = scl_pkg::SCL_MID;
        end
      end
      default: begin
        state_nxt = scl_pkg::SCL_IDLE;
      end
    endcase
  end

  assign nxt_high = (state_nxt == scl_pkg::SCL_HIGH);
  assign nxt_mid = (state_nxt == scl_pkg::SCL_MID);
  // Ceiling follows the next state so it changes on the same edge as the grant
  assign state_ma = nxt_high ? scl_pkg::HIGH_LIMIT_MA :
    nxt_mid ? scl_pkg::MID_LIMIT_MA : scl_pkg::DEFAULT_LIMIT_MA;

  assign over_cap = link.passthrough_sink_attached_state & (state_ma > PASSTHROUGH_MA);
  assign capped_ma = over_cap ? PASSTHROUGH_MA : state_ma;

  // same deadline for high to mid
  always_comb begin
    rd_cnt_nxt = rd_cnt_r;
    if (!active) begin
      rd_cnt_nxt = '0;
    end else if (drop) begin
      rd_cnt_nxt = RD_LAST;
    end else if (rd_cnt_r != '0) begin
      rd_cnt_nxt = rd_cnt_r - RD_W'(1);
    end
  end

  always_comb begin
    grant_nxt.substate = state_nxt;
    grant_nxt.limit_ma = capped_ma;
    grant_nxt.reducing = (rd_cnt_nxt != '0);
  end

  // Pulse marks a move between live sub-states only, never attach or detach
  assign substate_moves = (state_nxt != state_r) & ~in_idle & active;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= scl_pkg::SCL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Candidate trails the synchronised code by one cycle to spot changes
  always_ff @(posedge mclk) begin
    if (rst) begin
      cand_r <= 2'h0;
    end else begin
      cand_r <= cc_sync_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      db_cnt_r <= '0;
    end else begin
      db_cnt_r <= db_cnt_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_cnt_r <= '0;
    end else begin
      rd_cnt_r <= rd_cnt_nxt;
    end
  end

  // Grant is registered so the load switch sees clean levels
  always_ff @(posedge mclk) begin
    if (rst) begin
      grant_r <= '{substate: scl_pkg::SCL_IDLE, limit_ma: scl_pkg::DEFAULT_LIMIT_MA, reducing: 1'b0};
    end else begin
      grant_r <= grant_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      advert_change_r <= 1'b0;
    end else begin
      advert_change_r <= substate_moves;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      raise_withheld_r <= 1'b0;
    end else begin
      raise_withheld_r <= raise_blocked;
    end
  end

  assign grant = grant_r;
  assign advert_change_pulse = advert_change_r;
  assign raise_withheld = raise_withheld_r;

endmodule : scl_current_fsm

// >>> scl_pkg.sv
package scl_pkg;

  // Clock rate of mclk
  localparam int unsigned CLK_MHZ = 100;

  // Advertisement-change debounce time, in microseconds
  localparam int unsigned ADVERT_DEBOUNCE_US = 10;
  localparam int unsigned ADVERT_DEBOUNCE_CYC =
    (ADVERT_DEBOUNCE_US * CLK_MHZ < 1) ? 1 : ADVERT_DEBOUNCE_US * CLK_MHZ;

  // Deadline for cutting draw after a lower advertisement, in microseconds
  localparam int unsigned REDUCE_DEADLINE_US = 40;
  localparam int unsigned REDUCE_DEADLINE_CYC =
    (REDUCE_DEADLINE_US * CLK_MHZ < 1) ? 1 : REDUCE_DEADLINE_US * CLK_MHZ;

  // Current ceilings in milliamps
  localparam int unsigned MA_W = 12;
  localparam logic [MA_W-1:0] DEFAULT_LIMIT_MA = 12'h1F4;
  localparam logic [MA_W-1:0] MID_LIMIT_MA = 12'h5DC;
  localparam logic [MA_W-1:0] HIGH_LIMIT_MA = 12'hBB8;
  localparam logic [MA_W-1:0] PASSTHROUGH_LIMIT_MA = 12'h9C4;

  // Sensed configuration-channel voltage range, as coded by the comparators
  typedef enum logic [1:0] {
    SCL_RANGE_DEFAULT = 2'h0,
    SCL_RANGE_MID = 2'h1,
    SCL_RANGE_HIGH = 2'h2,
    SCL_RANGE_NONE = 2'h3
  } scl_range_t;

  // Current sub-states, one-hot
  typedef enum logic [3:0] {
    SCL_IDLE = 4'h1,
    SCL_DEFAULT = 4'h2,
    SCL_MID = 4'h4,
    SCL_HIGH = 4'h8
  } scl_state_t;

  // Grant shown to the load switch
  typedef struct packed {
    scl_state_t substate;
    logic [MA_W-1:0] limit_ma;
    logic reducing;
  } scl_grant_t;

  // Attach and power conditions from the port controller
  typedef struct packed {
    logic sink_attached_state;
    logic passthrough_sink_attached_state;
    logic vbus_default;
    logic pd_contract;
  } scl_link_t;

endpackage : scl_pkg

// >>> scl_current_fsm_assertions.sv
`timescale 1ns/1ps
module scl_fsm_checker #(
  parameter int unsigned DEBOUNCE_CYC = 8,
  parameter int unsigned REDUCE_CYC = 5,
  parameter logic [scl_pkg::MA_W-1:0] PASSTHROUGH_MA = scl_pkg::PASSTHROUGH_LIMIT_MA
) (
  input wire logic mclk,
  input wire logic rst,
  input wire scl_pkg::scl_link_t link,
  input wire logic [1:0] sensed_cc_voltage,
  input wire logic high_current_enable,
  input wire scl_pkg::scl_grant_t grant,
  input wire logic advert_change_pulse,
  input wire logic raise_withheld
);
  wire logic act = (link.sink_attached_state | link.passthrough_sink_attached_state) & link.vbus_default
    & ~link.pd_contract;
  wire logic pt = link.passthrough_sink_attached_state;
  logic [7:0] stab_r;
  logic [7:0] red_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Cycles the raw range code has held still
  always_ff @(posedge mclk) begin
    if (rst || sensed_cc_voltage != $past(sensed_cc_voltage)) stab_r <= 8'h00;
    else if (stab_r != 8'hFF) stab_r <= stab_r + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (rst || !grant.reducing) red_r <= 8'h00;
    else red_r <= red_r + 8'h01;
  end
  sequence s_move;
    $past(grant.substate) != grant.substate && $past(grant.substate) != scl_pkg::SCL_IDLE
      && grant.substate != scl_pkg::SCL_IDLE;
  endsequence
  sequence s_drop;
    s_move ##0 grant.substate < $past(grant.substate);
  endsequence
  a_idle_when_off: assert property (!act |=> grant.substate == scl_pkg::SCL_IDLE)
    else $error("substate not idle while inactive");
  a_attach_default: assert property ($rose(act) |=> grant.substate == scl_pkg::SCL_DEFAULT)
    else $error("attach did not enter default");
  a_default_limit: assert property (grant.substate inside {scl_pkg::SCL_IDLE, scl_pkg::SCL_DEFAULT}
    |-> grant.limit_ma == scl_pkg::DEFAULT_LIMIT_MA) else $error("default limit wrong");
  a_passthrough_cap: assert property (pt && $past(pt) |-> grant.limit_ma <= PASSTHROUGH_MA)
    else $error("passthrough cap exceeded");
  a_debounce_hold: assert property (s_move |-> $past(stab_r, 4) >= DEBOUNCE_CYC - 3)
    else $error("move before range settled");
  a_move_pulse: assert property (s_move |-> advert_change_pulse)
    else $error("no pulse with move");
  a_withheld_default: assert property (raise_withheld |-> grant.substate == scl_pkg::SCL_DEFAULT)
    else $error("withheld flag outside default");
  a_drop_reduce: assert property (s_drop |-> grant.reducing)
    else $error("drop without reducing");
  a_reduce_length: assert property ($fell(grant.reducing) && grant.substate != scl_pkg::SCL_IDLE
    |-> red_r == REDUCE_CYC) else $error("reducing length wrong");
endmodule : scl_fsm_checker

// >>> scl_source_model.sv
`timescale 1ns/1ps
module scl_source_model (
  input wire logic mclk,
  input wire logic [1:0] advert,
  input wire logic [3:0] bounce,
  output logic [1:0] cc
);
  logic [1:0] last_r;
  logic [3:0] left_r;
  initial begin
    cc = 2'h3;
    last_r = 2'h3;
    left_r = 4'h0;
  end
  // A new advertisement shows the opposite code for a few cycles first
  always @(posedge mclk) begin
    if (advert != last_r) left_r = bounce;
    last_r = advert;
    if (left_r != 4'h0) left_r = left_r - 4'h1;
    cc <= #2 (left_r != 4'h0) ? ~advert : advert;
  end
endmodule : scl_source_model

// >>> tb_scl_current_fsm.sv
`timescale 1ns/1ps
module tb_scl_current_fsm;
  logic mclk;
  logic rst;
  scl_pkg::scl_link_t link;
  logic [1:0] advert;
  logic [3:0] bounce;
  logic [1:0] cc;
  logic hce;
  scl_pkg::scl_grant_t grant;
  logic [3:0] exp_st;
  logic [3:0] prev;
  logic acp;
  logic rwh;
  int n_pulse = 0;
  int n0;
  int n_mismatch;
  int n_checks;
  scl_current_fsm #(.DEBOUNCE_CYC(8), .REDUCE_CYC(5)) scl_current_fsm_i (.mclk(mclk), .rst(rst), .link(link),
    .sensed_cc_voltage(cc), .high_current_enable(hce), .grant(grant), .advert_change_pulse(acp),
    .raise_withheld(rwh));
  // Pulse stands from one rising edge to the next, so each is seen once here
  always @(negedge mclk) begin
    if (acp === 1'b1) n_pulse++;
  end
  scl_source_model scl_source_model_i (.mclk(mclk), .advert(advert), .bounce(bounce), .cc(cc));
  function automatic logic [3:0] step(logic [3:0] s, logic [1:0] c, logic e);
    if (c == 2'h3 || (s == 4'h2 && !e && c != 2'h0)) return s;
    return (c == 2'h0) ? 4'h2 : (c == 2'h1) ? 4'h4 : 4'h8;
  endfunction : step
  function automatic logic [11:0] lim(logic [3:0] s, logic p);
    lim = (s == 4'h4) ? scl_pkg::MID_LIMIT_MA : (s == 4'h8) ? scl_pkg::HIGH_LIMIT_MA : scl_pkg::DEFAULT_LIMIT_MA;
    if (p && lim > scl_pkg::PASSTHROUGH_LIMIT_MA) lim = scl_pkg::PASSTHROUGH_LIMIT_MA;
  endfunction : lim
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic wait_st(logic [3:0] e);
    n_checks++;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (grant.substate === e) return;
    end
    $display("[ERR] substate expected %0h seen %0h", e, grant.substate);
    n_mismatch++;
    tally_and_finish();
  endtask : wait_st
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    logic p;
    rst = 1'b1;
    link = '0;
    advert = 2'h0;
    bounce = 4'h0;
    hce = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'h4be014b1));
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk("substate", 4'h1, grant.substate);
    // Attached sink on default bus supply
    link = 4'hA;
    exp_st = 4'h2;
    wait_st(exp_st);
    for (int i = 0; i < 60; i++) begin
      p = 1'($urandom_range(1));
      link.sink_attached_state = !p;
      link.passthrough_sink_attached_state = p;
      hce = (exp_st != 4'h2) || 1'($urandom_range(1));
      advert = 2'($urandom_range(3));
      bounce = 4'($urandom_range(6));
      prev = exp_st;
      n0 = n_pulse;
      exp_st = step(exp_st, advert, hce);
      wait_st(exp_st);
      chk("reducing", 16'(exp_st < prev), 16'(grant.reducing));
      repeat (20) @(negedge mclk);
      chk("substate", 16'(exp_st), 16'(grant.substate));
      chk("reducing", 16'h0000, 16'(grant.reducing));
      chk("pulses", 16'(prev != exp_st), 16'(n_pulse - n0));
      chk("withheld", 16'(exp_st == 4'h2 && !hce && (advert == 2'h1 || advert == 2'h2)), 16'(rwh));
      chk("limit", 16'(lim(exp_st, p)), 16'(grant.limit_ma));
    end
    // Contract, bus loss and detach each park the machine
    for (int k = 0; k < 3; k++) begin
      link = (k == 0) ? 4'hB : (k == 1) ? 4'h8 : 4'h2;
      wait_st(4'h1);
      link = 4'hA;
      wait_st(4'h2);
      chk("limit", 16'(scl_pkg::DEFAULT_LIMIT_MA), 16'(grant.limit_ma));
    end
    tally_and_finish();
  end
endmodule : tb_scl_current_fsm
bind scl_current_fsm scl_fsm_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .REDUCE_CYC(REDUCE_CYC),
  .PASSTHROUGH_MA(PASSTHROUGH_MA)) scl_fsm_checker_i (.mclk(mclk), .rst(rst), .link(link),
  .sensed_cc_voltage(sensed_cc_voltage), .high_current_enable(high_current_enable), .grant(grant),
  .advert_change_pulse(advert_change_pulse), .raise_withheld(raise_withheld));
